/* asbl_params.svh */
// Constants for the asynchronous serial byte link
`ifndef ASBL_PARAMS_SVH
`define ASBL_PARAMS_SVH
`define ASBL_CLK_HZ        50000000
`define ASBL_BAUD          38400
`define ASBL_DATA_BITS     4'h8
`define ASBL_MODE_ASYNC8   8'h00
`define ASBL_BRR_RESET     8'h27
`define ASBL_SCR_RXIE      6
`define ASBL_SCR_TEIE      2
`define ASBL_SCR_TE        5
`define ASBL_SCR_RE        4
`define ASBL_SSR_TX_EMPTY_FLAG      7
`define ASBL_SSR_RDRF      6
`define ASBL_SSR_TX_END_FLAG      2
`define ASBL_SSR_RESET     8'h84
`endif

/* asbl_pkg.sv */
// Types for the asynchronous serial byte link
package asbl_pkg;
    typedef enum logic [3:0] {
        ASBL_TX_IDLE  = 4'h1,
        ASBL_TX_START = 4'h2,
        ASBL_TX_DATA  = 4'h4,
        ASBL_TX_STOP  = 4'h8
    } asbl_tx_e;
    typedef enum logic [3:0] {
        ASBL_RX_IDLE  = 4'h1,
        ASBL_RX_START = 4'h2,
        ASBL_RX_DATA  = 4'h4,
        ASBL_RX_STOP  = 4'h8
    } asbl_rx_e;
endpackage : asbl_pkg

/* asbl_link.sv */
// Asynchronous serial byte link channel with handshake and two-entry receive buffer
`timescale 1ns/100ps
`include "asbl_params.svh"
module asbl_link (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       module_stop_i,
    input  wire logic [7:0] serial_mode_reg_i,
    input  wire logic [7:0] bit_rate_reg_i,
    input  wire logic [7:0] serial_control_reg_i,
    input  wire logic [7:0] tx_data_reg_i,
    input  wire logic       tx_empty_clear_i,
    input  wire logic       tx_end_clear_i,
    input  wire logic       rx_read_i,
    input  wire logic       rts_local_i,
    input  wire logic       cts_peer_n_i,
    input  wire logic       serial_rx_pin_i,
    output logic            serial_tx_pin_o,
    output logic            rts_pin_n_o,
    output logic [7:0]      serial_status_reg_o,
    output logic [7:0]      rx_data_reg_o,
    output logic            rx_valid_o,
    output logic            tx_end_irq_o,
    output logic            rx_full_irq_o
);
    function automatic logic [15:0] bit_ticks(input logic [7:0] brr);
        bit_ticks = 16'((32'(brr) + 32'h1) * 32'h20);
    endfunction : bit_ticks

    logic       run;
    logic       async8;
    logic       tx_en;
    logic       rx_en;
    assign run = !module_stop_i;
    assign async8 = (serial_mode_reg_i == `ASBL_MODE_ASYNC8);
    assign tx_en = run && async8 && serial_control_reg_i[`ASBL_SCR_TE];
    assign rx_en = run && async8 && serial_control_reg_i[`ASBL_SCR_RE];

    // Transmitter state
    asbl_pkg::asbl_tx_e tx_state;
    asbl_pkg::asbl_tx_e next_tx_state;
    logic [15:0]        tx_cnt;
    logic [15:0]        next_tx_cnt;
    logic [3:0]         tx_bit;
    logic [3:0]         next_tx_bit;
    logic [7:0]         tx_shift;
    logic [7:0]         next_tx_shift;
    logic               tx_line;
    logic               next_tx_line;
    logic               tx_empty_flag;
    logic               next_tx_empty_flag;
    logic               tx_end_flag;
    logic               next_tx_end_flag;
    logic               tx_tick;

    assign tx_tick = (tx_cnt == 16'h0000);

    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_cnt   = tx_tick ? 16'(bit_ticks(bit_rate_reg_i) - 16'h1) : 16'(tx_cnt - 16'h1);
        next_tx_bit   = tx_bit;
        next_tx_shift = tx_shift;
        next_tx_line  = tx_line;
        next_tx_empty_flag     = tx_empty_flag;
        next_tx_end_flag     = tx_end_flag;
        if (tx_end_clear_i)
        begin
            next_tx_end_flag = 1'b0;
        end
        // clearing empty flag requests a send
        if (tx_empty_clear_i)
        begin
            next_tx_empty_flag = 1'b0;
            next_tx_end_flag = 1'b0;
        end
        unique case (tx_state)
            asbl_pkg::ASBL_TX_IDLE:
            begin
                next_tx_line = 1'b1;
                if (tx_en && !tx_empty_flag && !tx_empty_clear_i && !cts_peer_n_i)
                begin
                    next_tx_shift = tx_data_reg_i;
                    next_tx_empty_flag     = 1'b1;
                    next_tx_state = asbl_pkg::ASBL_TX_START;
                    next_tx_cnt   = 16'(bit_ticks(bit_rate_reg_i) - 16'h1);
                    next_tx_line  = 1'b0;
                end
            end
            asbl_pkg::ASBL_TX_START:
            begin
                if (tx_tick)
                begin
                    next_tx_line  = tx_shift[0];
                    next_tx_bit   = 4'h1;
                    next_tx_state = asbl_pkg::ASBL_TX_DATA;
                end
            end
            asbl_pkg::ASBL_TX_DATA:
            begin
                if (tx_tick)
                begin
                    // eight bits, LSB first, then stop
                    if (tx_bit == `ASBL_DATA_BITS)
                    begin
                        next_tx_line  = 1'b1;
                        next_tx_state = asbl_pkg::ASBL_TX_STOP;
                    end
                    else
                    begin
                        next_tx_shift = {1'b0, tx_shift[7:1]};
                        next_tx_line  = tx_shift[1];
                        next_tx_bit   = 4'(tx_bit + 4'h1);
                    end
                end
            end
            asbl_pkg::ASBL_TX_STOP:
            begin
                if (tx_tick)
                begin
                    // end flag after final stop bit
                    next_tx_end_flag     = 1'b1;
                    next_tx_state = asbl_pkg::ASBL_TX_IDLE;
                end
            end
        endcase
        // Dropping the enable aborts only an unfinished frame
        if (!tx_en && tx_state != asbl_pkg::ASBL_TX_IDLE)
        begin
            next_tx_state = asbl_pkg::ASBL_TX_IDLE;
            next_tx_line  = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            tx_state <= asbl_pkg::ASBL_TX_IDLE;
            tx_cnt   <= 16'h0000;
            tx_bit   <= 4'h0;
            tx_shift <= 8'h00;
            tx_line  <= 1'b1;
            tx_empty_flag     <= 1'b1;
            tx_end_flag     <= 1'b1;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_cnt   <= next_tx_cnt;
            tx_bit   <= next_tx_bit;
            tx_shift <= next_tx_shift;
            tx_line  <= next_tx_line;
            tx_empty_flag     <= next_tx_empty_flag;
            tx_end_flag     <= next_tx_end_flag;
        end
    end

    // Receiver state
    asbl_pkg::asbl_rx_e rx_state;
    asbl_pkg::asbl_rx_e next_rx_state;
    logic [15:0]        rx_cnt;
    logic [15:0]        next_rx_cnt;
    logic [3:0]         rx_bit;
    logic [3:0]         next_rx_bit;
    logic [7:0]         rx_shift;
    logic [7:0]         next_rx_shift;
    logic               rx_push;
    logic               rx_tick;
    logic               buf_ready;

    assign rx_tick = (rx_cnt == 16'h0000);

    always_comb
    begin
        next_rx_state = rx_state;
        next_rx_cnt   = rx_tick ? 16'h0000 : 16'(rx_cnt - 16'h1);
        next_rx_bit   = rx_bit;
        next_rx_shift = rx_shift;
        rx_push       = 1'b0;
        unique case (rx_state)
            asbl_pkg::ASBL_RX_IDLE:
            begin
                // low level on receive pin starts a frame
                if (rx_en && !serial_rx_pin_i)
                begin
                    // Sample mid-bit to tolerate clock skew
                    next_rx_cnt   = 16'(bit_ticks(bit_rate_reg_i) >> 1);
                    next_rx_state = asbl_pkg::ASBL_RX_START;
                end
            end
            asbl_pkg::ASBL_RX_START:
            begin
                if (rx_tick)
                begin
                    next_rx_cnt   = 16'(bit_ticks(bit_rate_reg_i) - 16'h1);
                    next_rx_bit   = 4'h0;
                    next_rx_state = serial_rx_pin_i ? asbl_pkg::ASBL_RX_IDLE
                                                    : asbl_pkg::ASBL_RX_DATA;
                end
            end
            asbl_pkg::ASBL_RX_DATA:
            begin
                if (rx_tick)
                begin
                    next_rx_cnt   = 16'(bit_ticks(bit_rate_reg_i) - 16'h1);
                    next_rx_shift = {serial_rx_pin_i, rx_shift[7:1]};
                    next_rx_bit   = 4'(rx_bit + 4'h1);
                    if (rx_bit == 4'(`ASBL_DATA_BITS - 4'h1))
                    begin
                        next_rx_state = asbl_pkg::ASBL_RX_STOP;
                    end
                end
            end
            asbl_pkg::ASBL_RX_STOP:
            begin
                if (rx_tick)
                begin
                    // store byte only with a valid stop bit
                    rx_push       = serial_rx_pin_i;
                    next_rx_state = asbl_pkg::ASBL_RX_IDLE;
                end
            end
        endcase
        if (!rx_en)
        begin
            next_rx_state = asbl_pkg::ASBL_RX_IDLE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rx_state <= asbl_pkg::ASBL_RX_IDLE;
            rx_cnt   <= 16'h0000;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h00;
        end
        else
        begin
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
            rx_bit   <= next_rx_bit;
            rx_shift <= next_rx_shift;
        end
    end

    // Two-entry buffer between receiver and the receive data output
    logic [7:0] buf_mem [2];
    logic [7:0] next_buf_mem [2];
    logic [1:0] buf_cnt;
    logic [1:0] next_buf_cnt;
    logic       buf_wr;
    logic       buf_rd;

    assign buf_ready = (buf_cnt != 2'h2);
    assign buf_wr    = rx_push && buf_ready;
    assign buf_rd    = rx_read_i && (buf_cnt != 2'h0);

    always_comb
    begin
        next_buf_mem = buf_mem;
        next_buf_cnt = 2'(buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd});
        if (buf_rd)
        begin
            next_buf_mem[0] = buf_mem[1];
        end
        if (buf_wr)
        begin
            next_buf_mem[1'(buf_cnt - {1'b0, buf_rd})] = rx_shift;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            buf_mem[0] <= 8'h00;
            buf_mem[1] <= 8'h00;
            buf_cnt    <= 2'h0;
        end
        else
        begin
            buf_mem <= next_buf_mem;
            buf_cnt <= next_buf_cnt;
        end
    end

    // request line low only while the buffer has room
    assign rts_pin_n_o = !(rts_local_i && rx_en && buf_ready);
    assign serial_tx_pin_o = tx_line;
    assign rx_data_reg_o   = buf_mem[0];
    assign rx_valid_o      = (buf_cnt != 2'h0);

    always_comb
    begin
        serial_status_reg_o = 8'h00;
        serial_status_reg_o[`ASBL_SSR_TX_EMPTY_FLAG] = tx_empty_flag;
        serial_status_reg_o[`ASBL_SSR_RDRF] = rx_valid_o;
        serial_status_reg_o[`ASBL_SSR_TX_END_FLAG] = tx_end_flag;
    end

    assign tx_end_irq_o  = tx_end_flag && run && serial_control_reg_i[`ASBL_SCR_TEIE];
    assign rx_full_irq_o = rx_valid_o && run && serial_control_reg_i[`ASBL_SCR_RXIE];
endmodule : asbl_link

/* asbl_link_properties.sv */
// Port checker for the serial byte link
`timescale 1ns/100ps
module asbl_link_properties (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       module_stop_i,
    input wire logic [7:0] serial_control_reg_i,
    input wire logic       tx_empty_clear_i,
    input wire logic       tx_end_clear_i,
    input wire logic       rx_read_i,
    input wire logic       rts_local_i,
    input wire logic       serial_tx_pin_o,
    input wire logic       rts_pin_n_o,
    input wire logic [7:0] serial_status_reg_o,
    input wire logic [7:0] rx_data_reg_o,
    input wire logic       rx_valid_o,
    input wire logic       tx_end_irq_o,
    input wire logic       rx_full_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    reset_state_a : assert property (disable iff (1'b0) reset_i |=>
        serial_status_reg_o == 8'h84 && serial_tx_pin_o && !rx_valid_o)
        else $error("reset state wrong");
    spare_bits_zero_a : assert property ((serial_status_reg_o & 8'h3B) == 8'h00)
        else $error("spare status bits set");
    tx_irq_gate_a : assert property (tx_end_irq_o == (serial_status_reg_o[2]
        && serial_control_reg_i[2] && !module_stop_i)) else $error("tx end irq wrong");
    rx_irq_gate_a : assert property (rx_full_irq_o == (serial_status_reg_o[6]
        && rx_valid_o && serial_control_reg_i[6] && !module_stop_i))
        else $error("rx irq wrong");
    tx_end_flag_holds_a : assert property (serial_status_reg_o[2] && !tx_empty_clear_i
        && !tx_end_clear_i |=> serial_status_reg_o[2]) else $error("tx end dropped");
    clear_starts_a : assert property (tx_empty_clear_i |=> !serial_status_reg_o[7])
        else $error("tx empty not cleared");
    rts_gate_a : assert property (!rts_pin_n_o |-> rts_local_i && serial_control_reg_i[4])
        else $error("rts asserted wrongly");
    rx_head_holds_a : assert property (rx_valid_o && !rx_read_i |=>
        rx_valid_o && $stable(rx_data_reg_o)) else $error("rx head lost");
    idle_high_a : assert property (serial_status_reg_o[7] && serial_status_reg_o[2]
        |-> serial_tx_pin_o) else $error("tx pin low while idle");
    start_bit_a : assert property ($fell(serial_tx_pin_o) |=>
        (!serial_tx_pin_o || module_stop_i || !serial_control_reg_i[5])[*8])
        else $error("start bit too short");
endmodule : asbl_link_properties

bind asbl_link asbl_link_properties i_props (.clk_i, .reset_i, .module_stop_i,
    .serial_control_reg_i, .tx_empty_clear_i, .tx_end_clear_i, .rx_read_i, .rts_local_i,
    .serial_tx_pin_o, .rts_pin_n_o, .serial_status_reg_o, .rx_data_reg_o, .rx_valid_o,
    .tx_end_irq_o, .rx_full_irq_o);

/* asbl_peer.sv */
// Behavioural peer serial port with handshake lines
`timescale 1ns/100ps
module asbl_peer #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    input  wire logic rts_n_i,
    input  wire logic busy_i,
    output logic      line_o,
    output logic      cts_n_o
);
    logic [7:0] last_rx;
    int         rx_count;
    assign cts_n_o = busy_i;
    initial
    begin
        line_o = 1'b1;
        rx_count = 0;
    end
    // waits for request, then frames LSB first
    task put(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge clk_i);
        while (rts_n_i !== 1'b0) @(posedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            line_o <= f[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
    endtask : put
    // mid-bit sampling; a bad stop bit is not counted
    always
    begin
        @(negedge line_i);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk_i);
            last_rx[i] = line_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        if (line_i === 1'b1)
            rx_count++;
    end
endmodule : asbl_peer

/* testbench.sv */
// Self-checking bench for the serial byte link
`timescale 1ns/100ps
module testbench;
    localparam logic [7:0] BRR = 8'h01;
    logic       clk_i, reset_i, module_stop_i, tx_empty_clear_i, tx_end_clear_i, rx_read_i;
    logic       rts_local_i, cts_peer_n_i, serial_rx_pin_i, serial_tx_pin_o, rts_pin_n_o;
    logic       rx_valid_o, tx_end_irq_o, rx_full_irq_o, peer_busy;
    logic [7:0] serial_mode_reg_i, bit_rate_reg_i, serial_control_reg_i, tx_data_reg_i;
    logic [7:0] serial_status_reg_o, rx_data_reg_o;
    logic [7:0] tv [3] = '{8'hA5, 8'h01, 8'h80};
    int         fail_count, checks_done, cycles, sent, span;

    asbl_link i_dut (.clk_i, .reset_i, .module_stop_i, .serial_mode_reg_i, .bit_rate_reg_i,
        .serial_control_reg_i, .tx_data_reg_i, .tx_empty_clear_i, .tx_end_clear_i,
        .rx_read_i, .rts_local_i, .cts_peer_n_i, .serial_rx_pin_i, .serial_tx_pin_o,
        .rts_pin_n_o, .serial_status_reg_o, .rx_data_reg_o, .rx_valid_o, .tx_end_irq_o,
        .rx_full_irq_o);
    asbl_peer #(.BIT_CLKS((BRR + 1) * 32)) peer (.clk_i, .line_i(serial_tx_pin_o),
        .rts_n_i(rts_pin_n_o), .busy_i(peer_busy), .line_o(serial_rx_pin_i),
        .cts_n_o(cts_peer_n_i));

    task check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task tally_and_finish;
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // One-cycle strobe of read, tx-end clear and tx-empty clear
    task strobe(input logic [2:0] m);
        @(posedge clk_i);
        {rx_read_i, tx_end_clear_i, tx_empty_clear_i} <= m;
        @(posedge clk_i);
        {rx_read_i, tx_end_clear_i, tx_empty_clear_i} <= 3'b000;
    endtask : strobe
    task xmit(input logic [7:0] b);
        @(posedge clk_i);
        tx_data_reg_i <= b;
        strobe(3'b001);
        @(negedge clk_i);
        while (serial_status_reg_o[2] !== 1'b1) @(negedge clk_i);
        sent++;
        check(peer.last_rx, b);
        check(8'(peer.rx_count), 8'(sent));
    endtask : xmit

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Ceiling well above seven frames plus the stall
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        {module_stop_i, tx_empty_clear_i, tx_end_clear_i, rx_read_i, peer_busy} = '0;
        {reset_i, rts_local_i, serial_mode_reg_i, bit_rate_reg_i} = {2'b11, 8'h00, BRR};
        {serial_control_reg_i, tx_data_reg_i} = {8'h74, 8'h00};
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        check(serial_status_reg_o, 8'h84);
        foreach (tv[i])
            xmit(tv[i]);
        check({7'h00, tx_end_irq_o}, 8'h01);
        strobe(3'b010);
        @(negedge clk_i);
        check({serial_status_reg_o[7:1], tx_end_irq_o}, 8'h80);
        @(posedge clk_i);
        peer_busy <= 1'b1;
        fork
            xmit(8'h5A);
            begin
                repeat (700) @(negedge clk_i);
                check(8'(peer.rx_count), 8'(sent));
                @(posedge clk_i);
                peer_busy <= 1'b0;
            end
        join
        peer.put(8'h3C);
        @(negedge clk_i);
        check(rx_data_reg_o, 8'h3C);
        check({5'h00, rx_full_irq_o, rx_valid_o, serial_status_reg_o[6]}, 8'h07);
        @(posedge clk_i);
        serial_control_reg_i <= 8'h30;
        xmit(8'h7E);
        check({6'h00, tx_end_irq_o, rx_full_irq_o}, 8'h00);
        @(posedge clk_i);
        module_stop_i <= 1'b1;
        serial_control_reg_i <= 8'h74;
        @(negedge clk_i);
        check({6'h00, tx_end_irq_o, rx_full_irq_o}, 8'h00);
        @(posedge clk_i);
        module_stop_i <= 1'b0;
        @(negedge clk_i);
        check({6'h00, tx_end_irq_o, rx_full_irq_o}, 8'h03);
        peer.put(8'hC3);
        @(negedge clk_i);
        check({7'h00, rts_pin_n_o}, 8'h01);
        strobe(3'b100);
        @(negedge clk_i);
        check(rx_data_reg_o, 8'hC3);
        strobe(3'b100);
        @(negedge clk_i);
        check({5'h00, rx_full_irq_o, rx_valid_o, rts_pin_n_o}, 8'h00);
        // A mode other than asynchronous eight-bit must hold both directions idle
        @(posedge clk_i);
        serial_mode_reg_i <= 8'h01;
        bit_rate_reg_i    <= 8'h00;
        tx_data_reg_i     <= 8'hFF;
        strobe(3'b001);
        repeat (4) @(negedge clk_i);
        check({5'h00, serial_status_reg_o[7], rts_pin_n_o, serial_tx_pin_o}, 8'h03);
        @(posedge clk_i);
        serial_mode_reg_i <= 8'h00;
        // Divisor zero gives a start bit of 32 clocks
        @(negedge serial_tx_pin_o);
        @(negedge clk_i);
        while (serial_tx_pin_o === 1'b0)
        begin
            span++;
            @(negedge clk_i);
        end
        check(8'(span), 8'h20);
        tally_and_finish();
    end
endmodule : testbench
